/* File: pfss_pkg.sv */
package pfss_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned STROBE_MIN_NS    = 100;
  localparam int unsigned SAVE_TIME_MS     = 10;
  localparam int unsigned CONFIRM_DELAY_MS = 2;
  localparam int unsigned NS_PER_MS        = 1000000;

  // least width rounds up
  localparam int unsigned STROBE_CYC =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAVE_CYC    = SAVE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CONFIRM_CYC = CONFIRM_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 21;
  typedef logic [CNT_W-1:0] pfss_cnt_t;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    PFSS_IDLE    = 5'b00001,
    PFSS_CONFIRM = 5'b00010,
    PFSS_STROBE  = 5'b00100,
    PFSS_SAVING  = 5'b01000,
    PFSS_DONE    = 5'b10000
  } pfss_state_e;

endpackage

/* File: pfss_sync.sv */
`timescale 1ns/10ps

module pfss_sync (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic       level_ff;
  logic       nxt_level;

  // a change counts only once stages two and three agree
  always_comb begin
    nxt_sync  = {sync_ff[1:0], async_i};
    nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sync_ff  <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      sync_ff  <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;

endmodule // pfss_sync

/* File: pfss_seq.sv */
// Functional notes
// - strobe is driven low for at least 100 ns to request a save
// - strobe returns high before any further save request
// - save is requested at least 10 ms before regulation is lost
// - one raw detector pulse alone is never a power failure
// - after a loss indication wait about 2 ms then resample
// - still high on resample means real loss, else resume
// - restore strobe held low during power transitions blocks saves
// - software save requests are qualified by the write signal
`timescale 1ns/10ps

module pfss_seq
  import pfss_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic loss_i,
  input  wire logic supply_ok_i,
  input  wire logic sw_save_i,
  input  wire logic write_i,
  output logic      save_b_o,
  output logic      restore_b_o,
  output logic      busy_o,
  output logic      save_done_o,
  output logic      false_alarm_o
);
  import pfss_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // one terminal-count test for every timed state, so no window can
  // drift by a cycle against the others
  function automatic logic pfss_cnt_end(input pfss_cnt_t   cnt,
                                        input int unsigned cycles);
    pfss_cnt_end = (cnt == pfss_cnt_t'(cycles - 1));
  endfunction

  // resample verdict: loss still seen while the supply is judged good
  function automatic logic pfss_loss_real(input logic loss,
                                          input logic ok);
    pfss_loss_real = loss && ok;
  endfunction

  // states in which every new request is refused
  function automatic logic pfss_is_busy(input pfss_state_e st);
    pfss_is_busy = (st == PFSS_STROBE) || (st == PFSS_SAVING);
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned PIN_N = 2;

  logic             loss_s;
  logic             ok_s;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_sync;

  // bit 0 carries the loss detector, bit 1 the supply status
  assign pin_raw = {supply_ok_i, loss_i};

  // the loss and supply pins get the same three-stage filter, so a single-clock
  // glitch never reaches the sequencer from either of them
  for (genvar g = 0; g < PIN_N; g = g + 1) begin : g_pin_sync
    pfss_sync u_sync (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .async_i (pin_raw[g]),
      .level_o (pin_sync[g])
    );
  end

  assign loss_s = pin_sync[0];
  assign ok_s   = pin_sync[1];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  pfss_state_e state_ff;
  pfss_state_e nxt_state;
  // one counter times every window; the save window is the widest
  pfss_cnt_t   cnt_ff;
  pfss_cnt_t   nxt_cnt;
  logic        save_b_ff;
  logic        nxt_save_b;
  logic        restore_b_ff;
  logic        nxt_restore_b;
  logic        done_ff;
  logic        nxt_done;
  logic        false_ff;
  logic        nxt_false;
  logic        sw_req;

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  // a stray decode during power-up must not reach the memory without a write
  assign sw_req = sw_save_i & write_i;

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_save_b = 1'b1;
    case (state_ff)
      PFSS_IDLE: begin
        nxt_cnt = '0;
        // supply not judged good: a save begun now could not finish
        if (!ok_s) begin
          nxt_state = PFSS_IDLE;
        end else if (sw_req) begin
          nxt_state  = PFSS_STROBE;
          nxt_save_b = 1'b0;
        end else if (loss_s) begin
          nxt_state = PFSS_CONFIRM;
        end
      end
      PFSS_CONFIRM: begin
        // wait then resample; a single zero-crossing pulse is gone by now
        if (pfss_cnt_end(cnt_ff, CONFIRM_CYC)) begin
          nxt_cnt = '0;
          if (pfss_loss_real(loss_s, ok_s)) begin
            nxt_state  = PFSS_STROBE;
            nxt_save_b = 1'b0;
          end else begin
            nxt_state = PFSS_IDLE;
          end
        end else begin
          nxt_cnt = cnt_ff + pfss_cnt_t'(1);
        end
      end
      PFSS_STROBE: begin
        // falling edge starts the save; held low long enough
        if (pfss_cnt_end(cnt_ff, STROBE_CYC)) begin
          nxt_cnt   = cnt_ff + pfss_cnt_t'(1);
          nxt_state = PFSS_SAVING;
        end else begin
          nxt_cnt    = cnt_ff + pfss_cnt_t'(1);
          nxt_save_b = 1'b0;
        end
      end
      PFSS_SAVING: begin
        // requests ignored; the count runs on from the strobe so the
        // window is measured from the start of the request
        if (pfss_cnt_end(cnt_ff, SAVE_CYC)) begin
          nxt_state = PFSS_DONE;
        end else begin
          nxt_cnt = cnt_ff + pfss_cnt_t'(1);
        end
      end
      PFSS_DONE: begin
        nxt_cnt = '0;
        // rearm only after the request lines drop, so one hold cannot
        // chain saves back to back
        if (!sw_req && !loss_s) begin
          nxt_state = PFSS_IDLE;
        end
      end
      default: begin
        nxt_state = PFSS_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_ff  <= PFSS_IDLE;
      cnt_ff    <= '0;
      save_b_ff <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      save_b_ff <= nxt_save_b;
    end
  end

  // ---------------------------------------------------------------
  // status pulses and restore level
  // ---------------------------------------------------------------
  // decoded from the state being left, so each pulse lasts one cycle
  // and needs no clear of its own
  always_comb begin
    nxt_restore_b = ok_s;
    nxt_done      = (state_ff == PFSS_SAVING) && pfss_cnt_end(cnt_ff, SAVE_CYC);
    nxt_false     = (state_ff == PFSS_CONFIRM) && pfss_cnt_end(cnt_ff, CONFIRM_CYC) &&
                    !pfss_loss_real(loss_s, ok_s);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      restore_b_ff <= 1'b0;
      done_ff      <= 1'b0;
      false_ff     <= 1'b0;
    end else begin
      restore_b_ff <= nxt_restore_b;
      done_ff      <= nxt_done;
      false_ff     <= nxt_false;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // busy is a plain state decode so it drops in the same cycle the
  // sequencer leaves the save window
  assign save_b_o      = save_b_ff;
  assign restore_b_o   = restore_b_ff;
  assign busy_o        = pfss_is_busy(state_ff);
  assign save_done_o   = done_ff;
  assign false_alarm_o = false_ff;

endmodule // pfss_seq

/* File: pfss_asserts.sv */
`timescale 1ns/10ps
// ----
// save strobe checks
// ----
module pfss_asserts (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic loss_i,
  input wire logic supply_ok_i,
  input wire logic sw_save_i,
  input wire logic write_i,
  input wire logic save_b_o,
  input wire logic restore_b_o,
  input wire logic busy_o,
  input wire logic save_done_o,
  input wire logic false_alarm_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_strobe_width: assert property ($fell(save_b_o) |->
    (!save_b_o)[*8] ##1 !save_b_o ##1 !save_b_o ##1 save_b_o) else $error("strobe width wrong");
  a_no_restrobe: assert property ($rose(save_b_o) |-> save_b_o[*8])
    else $error("strobe restarted");
  a_strobe_busy: assert property (!save_b_o |-> busy_o) else $error("strobe outside busy");
  a_busy_hold: assert property ($rose(busy_o) |-> busy_o[*8]) else $error("busy dropped");
  a_restore_gate: assert property ($fell(save_b_o) |-> restore_b_o)
    else $error("strobe while restore low");
  a_write_qual: assert property ($fell(save_b_o) |->
    $past(sw_save_i && write_i) || $past(loss_i, 4) || $past(loss_i, 5)) else $error("bad cause");
  a_done_pulse: assert property (save_done_o |=> !save_done_o) else $error("done too long");
  a_alarm_idle: assert property (false_alarm_o |-> save_b_o && !busy_o)
    else $error("alarm during save");
  c_strobe: cover property ($fell(save_b_o));
  c_alarm: cover property (false_alarm_o);
  c_blocked: cover property (!restore_b_o && sw_save_i && write_i);
endmodule // pfss_asserts

bind pfss_seq pfss_asserts i_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .loss_i(loss_i),
  .supply_ok_i(supply_ok_i), .sw_save_i(sw_save_i), .write_i(write_i), .save_b_o(save_b_o),
  .restore_b_o(restore_b_o), .busy_o(busy_o), .save_done_o(save_done_o),
  .false_alarm_o(false_alarm_o));

/* File: pfss_mem_model.sv */
`timescale 1ns/10ps
// ----
// memory: acts on strobe edges only, no clock
// ----
module pfss_mem_model (
  input  wire logic save_b_i,
  input  wire logic restore_b_i,
  output logic      saving_o,
  output int        saves_o
);
  initial begin
    saving_o = 1'b0;
    saves_o  = 0;
  end
  // a low level alone or an edge mid-save starts nothing
  always @(negedge save_b_i) begin
    if (restore_b_i && !saving_o) begin
      saves_o++;
      saving_o = 1'b1;
      saving_o <= #10000000 1'b0;
    end
  end
endmodule // pfss_mem_model

/* File: tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
// ----
// bench
// ----
module tb_top;
  logic clock_i = 0, rst_b_i = 0, loss_i = 0, supply_ok_i = 0, sw_save_i = 0, write_i = 0;
  logic save_b_o, restore_b_o, busy_o, save_done_o, false_alarm_o, saving;
  int   failures = 0, compares = 0, cyc = 0, saves, lows;
  always #5 clock_i = ~clock_i;
  pfss_seq i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .loss_i(loss_i),
    .supply_ok_i(supply_ok_i), .sw_save_i(sw_save_i), .write_i(write_i), .save_b_o(save_b_o),
    .restore_b_o(restore_b_o), .busy_o(busy_o), .save_done_o(save_done_o),
    .false_alarm_o(false_alarm_o));
  pfss_mem_model i_mem (.save_b_i(save_b_o), .restore_b_i(restore_b_o), .saving_o(saving),
    .saves_o(saves));
  // count strobe-low cycles while the request inputs stand
  task automatic run(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge clock_i) #1;
      if (save_b_o === 1'b0) lows++;
    end
  endtask
  task automatic t_supply_block();
    supply_ok_i = 0; sw_save_i = 1; write_i = 1;
    run(20);
    `CHK("restore", 1'b0, restore_b_o)
    `CHK("lows", 0, lows)
    sw_save_i = 0; write_i = 0; supply_ok_i = 1;
    run(10);
    `CHK("restore", 1'b1, restore_b_o)
    $display("supply block done");
  endtask
  task automatic t_no_write();
    sw_save_i = 1;
    run(30);
    `CHK("lows", 0, lows)
    sw_save_i = 0;
    $display("write qualify done");
  endtask
  task automatic t_sw_save();
    sw_save_i = 1; write_i = 1;
    run(40);
    `CHK("lows", 10, lows)
    `CHK("saves", 1, saves)
    `CHK("busy", 1'b1, busy_o)
    `CHK("bus", 1'b1, saving)
    `CHK("done", 1'b0, save_done_o)
    sw_save_i = 0; write_i = 0;
    run(100);
    sw_save_i = 1; write_i = 1;
    run(100);
    `CHK("relows", 0, lows)
    $display("sw save done");
  endtask
  // hold reset, then look at the first two edges after release
  task automatic t_reset();
    rst_b_i = 0; sw_save_i = 0; write_i = 0; loss_i = 0;
    run(4);
    rst_b_i = 1;
    repeat (2) begin
      run(1);
      `CHK("save_b", 1'b1, save_b_o)
      `CHK("busy", 1'b0, busy_o)
      `CHK("restore", 1'b0, restore_b_o)
      `CHK("done", 1'b0, save_done_o)
      `CHK("alarm", 1'b0, false_alarm_o)
    end
    run(5);
  endtask
  // a one-clock detector pulse must leave the sequencer idle
  task automatic t_glitch();
    loss_i = 1;
    run(1);
    loss_i = 0;
    run(8);
    sw_save_i = 1; write_i = 1;
    run(20);
    `CHK("lows", 10, lows)
    `CHK("saves", 1, saves)
    `CHK("alarm", 1'b0, false_alarm_o)
    sw_save_i = 0; write_i = 0;
    $display("glitch filter done");
  endtask
  // a held loss indication must not strobe before the resample time
  task automatic t_loss_wait();
    loss_i = 1;
    run(10);
    sw_save_i = 1; write_i = 1;
    run(990);
    `CHK("lows", 0, lows)
    `CHK("busy", 1'b0, busy_o)
    `CHK("alarm", 1'b0, false_alarm_o)
    `CHK("restore", 1'b1, restore_b_o)
    sw_save_i = 0; write_i = 0; loss_i = 0;
    $display("loss wait done");
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    t_reset();
    t_supply_block();
    t_no_write();
    t_sw_save();
    t_reset();
    t_glitch();
    t_reset();
    t_loss_wait();
    t_reset();
    print_verdict();
  end
endmodule // tb_top
